// ===== scs_pkg.sv
// Summary of operation
// - Each winding change holds the power-stage gating off for a 50 to 10000 ms time, default 150 ms.
// - After the gate-off time the output current stays limited for 0 to 10000 ms, default 500 ms.
// - While limited the current is clamped to 0 to 120 percent, default 75, released at the end.
// - Exactly one of the two winding contactors is energised at any time.
// - External stop supervision runs only with supply type bit 0040 hex set and selector at 4.
// - External stop alone raises warning EA, with no stop state and no deceleration.
// - Without a drive stop in 30 s plus the extra delay, cutoff and alarm 6F assert together.
// - A drive stop inside the window turns EA into E7; a later cutoff command gives stop state.
// - Alarm policy 2 or 3 raises alarm 6F even when the drive stop came in time.
// - Once the drive stop is cancelled, ready-on is accepted but alarm 6F still follows at 30 s plus the extra delay.
// - When the supply cuts the contactor the drive applies no braking and the motor coasts.
// - A host stop command makes the drive decelerate.
package scs_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_TICK_NS = 1000000;
  localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int ESTOP_FIXED_S = 30;

  // Register byte offsets
  localparam logic [7:0] OFS_SUPPLY = 8'h00;
  localparam logic [7:0] OFS_GATE_MS = 8'h04;
  localparam logic [7:0] OFS_LIMIT_MS = 8'h08;
  localparam logic [7:0] OFS_LIMIT_LVL = 8'h0C;
  localparam logic [7:0] OFS_EXTRA_S = 8'h10;
  localparam logic [7:0] OFS_POLICY = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // Reset values and limits
  localparam logic [15:0] RST_SUPPLY = 16'h0000;
  localparam logic [13:0] RST_GATE_MS = 14'h0096;
  localparam logic [13:0] RST_LIMIT_MS = 14'h01F4;
  localparam logic [6:0] RST_LIMIT_LVL = 7'h4B;
  localparam logic [15:0] RST_EXTRA_S = 16'h0000;
  localparam logic [3:0] RST_POLICY = 4'h0;
  localparam logic [13:0] GATE_MS_MIN = 14'h0032;
  localparam logic [13:0] TIME_MS_MAX = 14'h2710;
  localparam logic [6:0] LIMIT_LVL_MAX = 7'h78;
  localparam logic [15:0] EXT_STOP_ENABLE_BIT = 16'h0040;
  localparam logic [3:0] EXT_STOP_SELECTOR = 4'h4;
  localparam logic [3:0] POLICY_ALWAYS_A = 4'h2;
  localparam logic [3:0] POLICY_ALWAYS_B = 4'h3;

  // Interrupt bit positions
  localparam int IRQ_W = 6;
  localparam int IRQ_SWITCH = 0;
  localparam int IRQ_LIMIT_END = 1;
  localparam int IRQ_WARN_EXT = 2;
  localparam int IRQ_WARN_STOP = 3;
  localparam int IRQ_ALARM = 4;
  localparam int IRQ_STOP_STATE = 5;

  typedef enum logic [2:0] {
    ES_IDLE = 3'b000,
    ES_EXT_WARN = 3'b001,
    ES_STOP_WARN = 3'b011,
    ES_STOP = 3'b010,
    ES_ALARM = 3'b110
  } scs_estop_state_t;

  typedef struct packed {
    logic [15:0] supply_type_setting;
    logic [13:0] winding_switch_gate_off_time;
    logic [13:0] post_switch_limit_duration;
    logic [6:0] post_switch_limit_level;
    logic [15:0] extra_estop_delay;
    logic [3:0] estop_alarm_policy;
  } scs_cfg_t;

endpackage

// ===== scs_tick.sv
module scs_tick #(
  parameter int DIV = 40000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Advance and tick
  input wire logic advance_i,
  output logic tick_o
);

  localparam int W = $clog2(DIV);

  initial begin
    if (DIV < 2) begin
      $error("scs_tick: DIV must be at least 2");
    end
  end

  logic [W-1:0] cnt_reg;
  wire at_end = (cnt_reg == W'(DIV - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= advance_i & at_end;
      if (advance_i) begin
        cnt_reg <= at_end ? '0 : cnt_reg + W'(1);
      end
    end
  end

endmodule

// ===== scs_timer.sv
module scs_timer #(
  parameter int W = 14
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  input wire logic tick_i,
  // Status
  output logic busy_o,
  output logic done_o
);

  initial begin
    if (W < 2) begin
      $error("scs_timer: W must be at least 2");
    end
  end

  logic [W-1:0] cnt_reg;
  wire last = tick_i & (cnt_reg == W'(1));

  // Loading zero cancels a running count without a done pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= last & ~load_i;
      if (load_i) begin
        cnt_reg <= value_i;
      end else if (tick_i && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - W'(1);
      end
    end
  end

  assign busy_o = (cnt_reg != '0);

endmodule

// ===== scs_top.sv
module scs_top #(
  parameter int MS_CYCLES = scs_pkg::MS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Winding control
  input wire logic low_speed_winding_select_i,
  output logic gate_enable_o,
  output logic current_limit_active_o,
  output logic [6:0] current_limit_level_o,
  output logic low_winding_contactor_o,
  output logic second_winding_contactor_o,
  // Emergency stop
  input wire logic [3:0] supply_selector_i,
  input wire logic external_estop_input_i,
  input wire logic drive_estop_i,
  input wire logic contactor_shutoff_cmd_i,
  input wire logic alarm_reset_i,
  input wire logic ready_on_i,
  output logic contactor_cutoff_output_o,
  output logic decel_active_o,
  output logic ready_o,
  output logic warn_ext_o,
  output logic warn_stop_o,
  output logic alarm_supply_o,
  output logic estop_state_o,
  // Interrupt
  output logic irq_o
);

  initial begin
    if (MS_CYCLES < 2) begin
      $error("scs_top: MS_CYCLES must be at least 2");
    end
  end

  function automatic logic [13:0] clamp14(input logic [13:0] v,
                                           input logic [13:0] lo,
                                           input logic [13:0] hi);
    clamp14 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Configuration registers and APB decode
  scs_pkg::scs_cfg_t cfg_reg;
  logic [scs_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [scs_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [31:0] rdata_reg;

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_supply = (paddr == scs_pkg::OFS_SUPPLY);
  wire hit_gate = (paddr == scs_pkg::OFS_GATE_MS);
  wire hit_limit = (paddr == scs_pkg::OFS_LIMIT_MS);
  wire hit_lvl = (paddr == scs_pkg::OFS_LIMIT_LVL);
  wire hit_extra = (paddr == scs_pkg::OFS_EXTRA_S);
  wire hit_policy = (paddr == scs_pkg::OFS_POLICY);
  wire hit_state = (paddr == scs_pkg::OFS_STATE);
  wire hit_istat = (paddr == scs_pkg::OFS_IRQ_STAT);
  wire hit_imask = (paddr == scs_pkg::OFS_IRQ_MASK);
  wire mapped = hit_supply | hit_gate | hit_limit | hit_lvl | hit_extra |
                hit_policy | hit_state | hit_istat | hit_imask;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = rdata_reg;

  // Winding switch sequencing
  logic sel_reg;
  logic gate_busy;
  logic gate_done;
  logic limit_busy;
  logic limit_done;
  logic ms_tick;
  logic s_tick;

  wire sel_change = (low_speed_winding_select_i != sel_reg);
  wire [13:0] gate_ms = clamp14(cfg_reg.winding_switch_gate_off_time,
                                scs_pkg::GATE_MS_MIN, scs_pkg::TIME_MS_MAX);
  wire [13:0] limit_ms = clamp14(cfg_reg.post_switch_limit_duration,
                                 14'h0000, scs_pkg::TIME_MS_MAX);
  wire [13:0] lvl_wide = clamp14({7'h00, cfg_reg.post_switch_limit_level},
                                 14'h0000, {7'h00, scs_pkg::LIMIT_LVL_MAX});
  // A select edge during the limit period restarts gate-off and drops limit
  wire limit_load = sel_change | gate_done;
  wire [13:0] limit_value = sel_change ? 14'h0000 : limit_ms;

  scs_tick #(
    .DIV(MS_CYCLES)
  ) u_ms_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .advance_i(1'b1),
    .tick_o(ms_tick)
  );

  scs_tick #(
    .DIV(scs_pkg::MS_PER_S)
  ) u_s_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .advance_i(ms_tick),
    .tick_o(s_tick)
  );

  scs_timer #(
    .W(14)
  ) u_gate_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(sel_change),
    .value_i(gate_ms),
    .tick_i(ms_tick),
    .busy_o(gate_busy),
    .done_o(gate_done)
  );

  scs_timer #(
    .W(14)
  ) u_limit_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(limit_load),
    .value_i(limit_value),
    .tick_i(ms_tick),
    .busy_o(limit_busy),
    .done_o(limit_done)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg <= 1'b0;
      gate_enable_o <= 1'b0;
      current_limit_active_o <= 1'b0;
      current_limit_level_o <= '0;
      low_winding_contactor_o <= 1'b0;
      second_winding_contactor_o <= 1'b1;
    end else begin
      sel_reg <= low_speed_winding_select_i;
      gate_enable_o <= ~(sel_change | gate_busy);
      current_limit_active_o <= limit_busy & ~sel_change;
      current_limit_level_o <= lvl_wide[6:0];
      // Contactors flip while gating is off, one always energised
      low_winding_contactor_o <= low_speed_winding_select_i;
      second_winding_contactor_o <= ~low_speed_winding_select_i;
    end
  end

  // External emergency stop supervision
  scs_pkg::scs_estop_state_t es_reg;
  scs_pkg::scs_estop_state_t es_next;
  logic stop_cancelled_reg;
  logic es_busy;
  logic es_done;

  wire sup_on = ((cfg_reg.supply_type_setting &
                  scs_pkg::EXT_STOP_ENABLE_BIT) != 16'h0000) &&
                (supply_selector_i == scs_pkg::EXT_STOP_SELECTOR);
  wire ext_active = sup_on & external_estop_input_i;
  wire policy_alarm = (cfg_reg.estop_alarm_policy ==
                       scs_pkg::POLICY_ALWAYS_A) ||
                      (cfg_reg.estop_alarm_policy ==
                       scs_pkg::POLICY_ALWAYS_B);
  wire es_start = ext_active & (es_reg == scs_pkg::ES_IDLE);
  wire [15:0] es_window = 16'(cfg_reg.extra_estop_delay +
                              16'(scs_pkg::ESTOP_FIXED_S));

  scs_timer #(
    .W(16)
  ) u_estop_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(es_start),
    .value_i(es_window),
    .tick_i(s_tick),
    .busy_o(es_busy),
    .done_o(es_done)
  );

  always_comb begin
    es_next = es_reg;
    unique case (es_reg)
      scs_pkg::ES_IDLE: begin
        if (ext_active) begin
          es_next = drive_estop_i ? scs_pkg::ES_STOP_WARN
                                  : scs_pkg::ES_EXT_WARN;
        end
      end
      scs_pkg::ES_EXT_WARN: begin
        if (!ext_active) begin
          es_next = scs_pkg::ES_IDLE;
        end else if (es_done) begin
          es_next = scs_pkg::ES_ALARM;
        end else if (drive_estop_i) begin
          es_next = scs_pkg::ES_STOP_WARN;
        end
      end
      scs_pkg::ES_STOP_WARN: begin
        if (es_done && (policy_alarm || stop_cancelled_reg)) begin
          es_next = scs_pkg::ES_ALARM;
        end else if (!sup_on || (!ext_active && !drive_estop_i)) begin
          // Supervision switched off or both stop inputs released: E7 is a supervision warning, drop it
          es_next = scs_pkg::ES_IDLE;
        end else if (contactor_shutoff_cmd_i && drive_estop_i) begin
          es_next = scs_pkg::ES_STOP;
        end
      end
      scs_pkg::ES_STOP: begin
        if (es_done && policy_alarm) begin
          es_next = scs_pkg::ES_ALARM;
        end else if (!drive_estop_i) begin
          es_next = ext_active ? scs_pkg::ES_STOP_WARN : scs_pkg::ES_IDLE;
        end
      end
      scs_pkg::ES_ALARM: begin
        if (alarm_reset_i && !ext_active) begin
          es_next = scs_pkg::ES_IDLE;
        end
      end
      default: es_next = scs_pkg::ES_IDLE;
    endcase
  end

  wire in_alarm = (es_next == scs_pkg::ES_ALARM);
  wire in_stop = (es_next == scs_pkg::ES_STOP);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      es_reg <= scs_pkg::ES_IDLE;
      stop_cancelled_reg <= 1'b0;
      contactor_cutoff_output_o <= 1'b0;
      decel_active_o <= 1'b0;
      ready_o <= 1'b0;
      warn_ext_o <= 1'b0;
      warn_stop_o <= 1'b0;
      alarm_supply_o <= 1'b0;
      estop_state_o <= 1'b0;
    end else begin
      es_reg <= es_next;
      // Remembers a stop that came and went inside the window
      if (es_next == scs_pkg::ES_IDLE || es_next == scs_pkg::ES_EXT_WARN) begin
        stop_cancelled_reg <= 1'b0;
      end else if (!drive_estop_i) begin
        stop_cancelled_reg <= 1'b1;
      end
      contactor_cutoff_output_o <= in_alarm;
      alarm_supply_o <= in_alarm;
      // Supply cut the contactor: no braking, the motor coasts
      decel_active_o <= drive_estop_i & ~in_alarm;
      ready_o <= ready_on_i & ~drive_estop_i & ~in_alarm;
      warn_ext_o <= (es_next == scs_pkg::ES_EXT_WARN);
      warn_stop_o <= (es_next == scs_pkg::ES_STOP_WARN);
      estop_state_o <= in_stop |
                       (drive_estop_i & ~ext_active & ~in_alarm);
    end
  end

  // Interrupts: set wins over the read-clear of the same cycle
  wire [scs_pkg::IRQ_W-1:0] irq_events = {
    in_stop & (es_reg != scs_pkg::ES_STOP),
    in_alarm & (es_reg != scs_pkg::ES_ALARM),
    (es_next == scs_pkg::ES_STOP_WARN) & (es_reg != scs_pkg::ES_STOP_WARN),
    (es_next == scs_pkg::ES_EXT_WARN) & (es_reg != scs_pkg::ES_EXT_WARN),
    limit_done,
    sel_change
  };
  // Clear only what the setup cycle latched, so nothing unseen is lost
  wire [scs_pkg::IRQ_W-1:0] irq_clr =
    (access & ~pwrite & hit_istat) ? rdata_reg[scs_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_events;
      if (wr && hit_imask) begin
        irq_mask_reg <= pwdata[scs_pkg::IRQ_W-1:0];
      end
      irq_o <= |(((irq_stat_reg & ~irq_clr) | irq_events) & irq_mask_reg);
    end
  end

  // Register writes and read data capture
  wire [31:0] state_word = {
    23'h000000, es_reg, stop_cancelled_reg, limit_busy, gate_busy,
    sup_on, sel_reg, es_busy
  };
  wire [31:0] rd_mux =
    hit_supply ? {16'h0000, cfg_reg.supply_type_setting} :
    hit_gate ? {18'h00000, cfg_reg.winding_switch_gate_off_time} :
    hit_limit ? {18'h00000, cfg_reg.post_switch_limit_duration} :
    hit_lvl ? {25'h0000000, cfg_reg.post_switch_limit_level} :
    hit_extra ? {16'h0000, cfg_reg.extra_estop_delay} :
    hit_policy ? {28'h0000000, cfg_reg.estop_alarm_policy} :
    hit_state ? state_word :
    hit_istat ? {26'h0000000, irq_stat_reg} :
    hit_imask ? {26'h0000000, irq_mask_reg} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg.supply_type_setting <= scs_pkg::RST_SUPPLY;
      cfg_reg.winding_switch_gate_off_time <= scs_pkg::RST_GATE_MS;
      cfg_reg.post_switch_limit_duration <= scs_pkg::RST_LIMIT_MS;
      cfg_reg.post_switch_limit_level <= scs_pkg::RST_LIMIT_LVL;
      cfg_reg.extra_estop_delay <= scs_pkg::RST_EXTRA_S;
      cfg_reg.estop_alarm_policy <= scs_pkg::RST_POLICY;
      rdata_reg <= 32'h00000000;
    end else begin
      if (setup && !pwrite) begin
        rdata_reg <= rd_mux;
      end
      if (wr && hit_supply) begin
        cfg_reg.supply_type_setting <= pwdata[15:0];
      end
      if (wr && hit_gate) begin
        cfg_reg.winding_switch_gate_off_time <= pwdata[13:0];
      end
      if (wr && hit_limit) begin
        cfg_reg.post_switch_limit_duration <= pwdata[13:0];
      end
      if (wr && hit_lvl) begin
        cfg_reg.post_switch_limit_level <= pwdata[6:0];
      end
      if (wr && hit_extra) begin
        cfg_reg.extra_estop_delay <= pwdata[15:0];
      end
      if (wr && hit_policy) begin
        cfg_reg.estop_alarm_policy <= pwdata[3:0];
      end
    end
  end

endmodule

// ===== scs_assertions.sv
module scs_assertions #(
  parameter int MS_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] supply_selector_i,
  input wire logic drive_estop_i,
  input wire logic gate_enable_o,
  input wire logic current_limit_active_o,
  input wire logic [6:0] current_limit_level_o,
  input wire logic low_winding_contactor_o,
  input wire logic second_winding_contactor_o,
  input wire logic contactor_cutoff_output_o,
  input wire logic alarm_supply_o,
  input wire logic decel_active_o,
  input wire logic warn_ext_o,
  input wire logic warn_stop_o,
  input wire logic estop_state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_ONE_CONTACTOR:
    assert property (low_winding_contactor_o != second_winding_contactor_o)
    else $error("both winding contactors in the same state");
  AST_GATE_OFF_ON_SWITCH:
    assert property ($changed(low_winding_contactor_o) |-> !gate_enable_o)
    else $error("gating on while contactors move");
  AST_GATE_OFF_HOLDS:
    assert property ($fell(gate_enable_o) |=> !gate_enable_o [*8])
    else $error("gate-off period too short");
  AST_LIMIT_AFTER_GATE:
    assert property ($rose(current_limit_active_o) |-> gate_enable_o)
    else $error("current limit started during gate-off");
  AST_LIMIT_LEVEL:
    assert property (current_limit_active_o |-> current_limit_level_o <= 7'h78)
    else $error("current clamp above 120 percent");
  AST_CUTOFF_WITH_ALARM:
    assert property (contactor_cutoff_output_o == alarm_supply_o)
    else $error("cutoff and supply alarm not together");
  AST_COAST_IN_ALARM:
    assert property (alarm_supply_o |-> !decel_active_o)
    else $error("braking while supply cut the contactor");
  AST_EXT_WARN_ONLY:
    assert property (warn_ext_o |-> !estop_state_o && !decel_active_o)
    else $error("stop state or deceleration on external input alone");
  AST_SUPERVISION_OFF:
    assert property ((supply_selector_i != 4'h4) [*2] |->
      !warn_ext_o && !warn_stop_o)
    else $error("supervision warning with selector not at 4");
  AST_NO_DECEL_IDLE:
    assert property (!drive_estop_i [*2] |-> !decel_active_o)
    else $error("deceleration without a host stop");
endmodule

bind scs_top scs_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .supply_selector_i(supply_selector_i),
  .drive_estop_i(drive_estop_i),
  .gate_enable_o(gate_enable_o),
  .current_limit_active_o(current_limit_active_o),
  .current_limit_level_o(current_limit_level_o),
  .low_winding_contactor_o(low_winding_contactor_o),
  .second_winding_contactor_o(second_winding_contactor_o),
  .contactor_cutoff_output_o(contactor_cutoff_output_o),
  .alarm_supply_o(alarm_supply_o),
  .decel_active_o(decel_active_o),
  .warn_ext_o(warn_ext_o),
  .warn_stop_o(warn_stop_o),
  .estop_state_o(estop_state_o)
);

// ===== scs_host_model.sv
module scs_host_model (
  // Clock and drive status
  input wire logic clk_i,
  input wire logic gate_enable_i,
  input wire logic limit_active_i,
  // Host commands
  output logic select_o,
  output logic [3:0] selector_o,
  output logic ext_stop_o,
  output logic drive_stop_o,
  output logic shutoff_o,
  output logic position_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pending;
  logic gate_seen;

  initial begin
    select_o = 1'b0;
    selector_o = 4'h0;
    ext_stop_o = 1'b0;
    drive_stop_o = 1'b0;
    shutoff_o = 1'b0;
    position_ok_o = 1'b0;
    pending = 1'b0;
    gate_seen = 1'b0;
  end

  // Pending bridges the cycle before the drive reacts to the new select
  always @(posedge clk_i) begin
    if (!gate_enable_i)
      pending <= 1'b0;
    // Gate must be seen on for a cycle, as the limit rises one cycle later
    gate_seen <= gate_enable_i;
    position_ok_o <= gate_enable_i && gate_seen && !limit_active_i &&
                     !pending;
  end

  task automatic switch_winding();
    @(posedge clk_i);
    select_o <= ~select_o;
    pending <= 1'b1;
  endtask

  task automatic set_stop(input logic [3:0] sel, input logic ext,
                          input logic drv, input logic cut);
    @(posedge clk_i);
    selector_o <= sel;
    ext_stop_o <= ext;
    drive_stop_o <= drv;
    // The off-delay cut only follows a stop that is already decelerating
    shutoff_o <= cut & drive_stop_o;
  endtask
endmodule

// ===== test_spindle_coil_switch_estop_sequencer.sv
module test_spindle_coil_switch_estop_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, gate_en, lim_act, sel, ext, drv;
  logic cut, pos_ok, ready_on = 1'b0, alarm_rst = 1'b0, cutoff, alarm;
  logic decel, ready, w_ext, w_stop, stop_st, irq, c_low, c_second;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic [6:0] lvl;
  logic [3:0] selpos;
  logic [32:0] exp_q[$];
  int fails = 0, check_count = 0, cycles = 0, n;
  logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
  logic [31:0] rv [7] = '{32'h0, 32'h96, 32'h1F4, 32'h4B, 32'h0, 32'h0,
                          32'h0};

  scs_top #(.MS_CYCLES(2)) DUT (.clk_i(clk_i), .rst_i(rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_winding_select_i(sel), .gate_enable_o(gate_en),
    .current_limit_active_o(lim_act), .current_limit_level_o(lvl),
    .low_winding_contactor_o(c_low), .second_winding_contactor_o(c_second),
    .supply_selector_i(selpos), .external_estop_input_i(ext),
    .drive_estop_i(drv), .contactor_shutoff_cmd_i(cut),
    .alarm_reset_i(alarm_rst), .ready_on_i(ready_on),
    .contactor_cutoff_output_o(cutoff), .decel_active_o(decel),
    .ready_o(ready), .warn_ext_o(w_ext), .warn_stop_o(w_stop),
    .alarm_supply_o(alarm), .estop_state_o(stop_st), .irq_o(irq));

  scs_host_model host (.clk_i(clk_i), .gate_enable_i(gate_en),
    .limit_active_i(lim_act), .select_o(sel), .selector_o(selpos),
    .ext_stop_o(ext), .drive_stop_o(drv), .shutoff_o(cut),
    .position_ok_o(pos_ok));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read expectations go to the queue; the monitor below compares them
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      exp_q.push_back(e);
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge clk_i) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0)
        chk(1'b1, 1'b0);
      else
        chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      results();
    end
  end

  task automatic settle(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  initial begin
    void'($urandom(32'hDB49A921));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
      apb(1'b0, ofs[i], 32'h0, {1'b0, rv[i]});
    apb(1'b0, 8'h24, 32'h0, {1'b1, 32'h0});
    v = $urandom;
    apb(1'b1, 8'h14, v, 33'h0);
    apb(1'b0, 8'h14, 32'h0, {29'h0, v[3:0]});
    apb(1'b1, 8'h04, 32'hA, 33'h0);
    apb(1'b1, 8'h08, 32'h14, 33'h0);
    apb(1'b1, 8'h0C, 32'h7F, 33'h0);
    apb(1'b1, 8'h20, 32'h3, 33'h0);
    host.switch_winding();
    settle(2);
    chk({c_low, c_second}, {sel, ~sel});
    n = 0;
    while (!gate_en && n < 30000) begin
      settle(1);
      n++;
    end
    chk(n >= 95 && n <= 104, 1'b1);
    settle(2);
    chk({lim_act, lvl, pos_ok}, {1'b1, 7'h78, 1'b0});
    n = 0;
    while (lim_act && n < 30000) begin
      settle(1);
      n++;
    end
    chk(n >= 34 && n <= 44, 1'b1);
    settle(3);
    chk({irq, pos_ok}, 2'b11);
    apb(1'b0, 8'h1C, 32'h0, 33'h3);
    settle(3);
    chk(irq, 1'b0);
    apb(1'b0, 8'h1C, 32'h0, 33'h0);
    apb(1'b1, 8'h20, 32'h0, 33'h0);
    apb(1'b1, 8'h00, 32'h40, 33'h0);
    host.set_stop(4'h0, 1'b1, 1'b0, 1'b0);
    settle(4);
    chk(w_ext, 1'b0);
    host.set_stop(4'h4, 1'b1, 1'b0, 1'b0);
    settle(3);
    chk({w_ext, stop_st, decel}, 3'b100);
    host.set_stop(4'h4, 1'b1, 1'b1, 1'b0);
    settle(3);
    chk({w_ext, w_stop, decel}, 3'b011);
    host.set_stop(4'h4, 1'b1, 1'b1, 1'b1);
    settle(3);
    chk({stop_st, irq}, 2'b10);
    // Mid-run reset also wipes the supply setting
    host.set_stop(4'h4, 1'b0, 1'b0, 1'b0);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b1, 8'h00, 32'h40, 33'h0);
    ready_on <= 1'b1;
    host.set_stop(4'h4, 1'b1, 1'b0, 1'b0);
    settle(3);
    chk({ready, w_ext}, 2'b11);
    n = 0;
    while (!alarm && n < 70000) begin
      settle(1);
      n++;
    end
    chk(n >= 57990 && n <= 60010, 1'b1);
    chk({cutoff, alarm, w_ext, decel, ready}, 5'b11000);
    results();
  end
endmodule
